/* core/hwm_unit.sv */
/*
 Halfword to word multiply datapath, one cycle from request to result.
 Assumes decode supplies operands and the exception word on the same
 cycle, and writeback honours cr_we; it never writes the exception reg.
*/
`include "hwm_regs.svh"

module hwm_unit
	import hwm_pkg::*;
(
	// Clock and reset
	input  wire logic     mclk,
	input  wire logic     rst_n,
	// Request from decode
	input  wire hwm_req_t req,
	// Result to writeback
	output hwm_rsp_t      rsp
);

	////////////////////////////////////////////////////////////////////
	function automatic logic [16:0] hwm_ext(input logic [15:0] h,
		input logic sgn);
		hwm_ext = {sgn & h[15], h};
	endfunction : hwm_ext

	wire logic [15:0] a_hi = req.src_a[`HWM_HI_MSB:`HWM_HI_LSB];
	wire logic [15:0] a_lo = req.src_a[`HWM_LO_MSB:`HWM_LO_LSB];
	wire logic [15:0] b_hi = req.src_b[`HWM_HI_MSB:`HWM_HI_LSB];
	wire logic [15:0] b_lo = req.src_b[`HWM_LO_MSB:`HWM_LO_LSB];

	// Cross takes low of first and high of second
	// Code 3 is unused by decode and falls through to the cross pairing
	wire logic [15:0] op_a = (req.sel == HWM_SEL_HIGH) ?
		a_hi : a_lo;
	wire logic [15:0] op_b = (req.sel == HWM_SEL_LOW) ?
		b_lo : b_hi;

	// 17-bit signed operands cover both signed and unsigned forms
	// One multiplier serves both forms, at the cost of a 17-bit array
	wire logic signed [16:0] ext_a =
		signed'(hwm_ext(op_a, req.is_signed));
	wire logic signed [16:0] ext_b =
		signed'(hwm_ext(op_b, req.is_signed));
	wire logic signed [33:0] full  = ext_a * ext_b;
	// Low 32 bits are exact for both forms
	wire logic [31:0] prod = full[31:0];

	wire logic res_zero = (prod == 32'h0000_0000);
	wire logic res_neg  = prod[31];
	// Signed compare with zero; summary overflow is read, never written
	wire logic [3:0] cr_nxt = {
		res_neg,
		~res_neg & ~res_zero,
		res_zero,
		req.fixed_point_exception_reg[`HWM_SO_BIT]};

	////////////////////////////////////////////////////////////////////
	hwm_rsp_t nxt_rsp;
	hwm_rsp_t rsp_ff;

	always_comb begin
		nxt_rsp.valid    = req.valid;
		nxt_rsp.product  = req.valid ? prod : rsp_ff.product;
		nxt_rsp.cr_we    = req.valid & req.record;
		nxt_rsp.cr_field = (req.valid & req.record) ? cr_nxt : rsp_ff.cr_field;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_ff <= '{1'b0, `HWM_RST_WORD, 1'b0, `HWM_RST_CR};
		end else begin
			rsp_ff <= nxt_rsp;
		end
	end

	// No exception register output exists: it cannot be written
	assign rsp = rsp_ff;

	////////////////////////////////////////////////////////////////////
	property p_prod;
		@(posedge mclk) disable iff (!rst_n)
		req.valid |=> rsp.valid && rsp.product == $past(prod);
	endproperty
	a_prod: assert property (p_prod) else $error("product mismatch");

	property p_cross;
		@(posedge mclk) disable iff (!rst_n)
		req.valid && req.sel == HWM_SEL_CROSS && !req.is_signed |=>
		rsp.product == $past(req.src_a[15:0]) * $past(req.src_b[31:16]);
	endproperty
	a_cross: assert property (p_cross) else $error("cross wrong");

	property p_high;
		@(posedge mclk) disable iff (!rst_n)
		req.valid && req.sel == HWM_SEL_HIGH && !req.is_signed |=>
		rsp.product == $past(req.src_a[31:16]) * $past(req.src_b[31:16]);
	endproperty
	a_high: assert property (p_high) else $error("high wrong");

	property p_low;
		@(posedge mclk) disable iff (!rst_n)
		req.valid && req.sel == HWM_SEL_LOW && req.is_signed |=>
		$signed(rsp.product) == $signed($past(req.src_a[15:0])) *
		$signed($past(req.src_b[15:0]));
	endproperty
	a_low: assert property (p_low) else $error("low signed wrong");

	property p_plain;
		@(posedge mclk) disable iff (!rst_n)
		!(req.valid && req.record) |=> !rsp.cr_we && $stable(rsp.cr_field);
	endproperty
	a_plain: assert property (p_plain) else $error("cr changed");

	property p_rec;
		@(posedge mclk) disable iff (!rst_n)
		req.valid && req.record |=> rsp.cr_we;
	endproperty
	a_rec: assert property (p_rec) else $error("cr not written");

	property p_cr;
		@(posedge mclk) disable iff (!rst_n)
		rsp.cr_we |-> rsp.cr_field[3:1] == {rsp.product[31],
		!rsp.product[31] && rsp.product != 0, rsp.product == 0};
	endproperty
	a_cr: assert property (p_cr) else $error("cr bits wrong");

	property p_so;
		@(posedge mclk) disable iff (!rst_n)
		req.valid && req.record |=> rsp.cr_field[0] == $past(req.fixed_point_exception_reg[31]);
	endproperty
	a_so: assert property (p_so) else $error("so not copied");

	////////////////////////////////////////////////////////////////////
	// The next three checks compare against plain products of the selected
	// halves, so a wrong pairing or extension in the datapath shows up.

	// Signed cross form
	property p_cross_s;
		@(posedge mclk) disable iff (!rst_n)
		req.valid && req.sel == HWM_SEL_CROSS && req.is_signed |=>
		$signed(rsp.product) == $signed($past(req.src_a[15:0])) *
		$signed($past(req.src_b[31:16]));
	endproperty
	a_cross_s: assert property (p_cross_s) else $error("cross signed");

	// Signed high form
	property p_high_s;
		@(posedge mclk) disable iff (!rst_n)
		req.valid && req.sel == HWM_SEL_HIGH && req.is_signed |=>
		$signed(rsp.product) == $signed($past(req.src_a[31:16])) *
		$signed($past(req.src_b[31:16]));
	endproperty
	a_high_s: assert property (p_high_s) else $error("high signed");

	// Unsigned low form
	property p_low_u;
		@(posedge mclk) disable iff (!rst_n)
		req.valid && req.sel == HWM_SEL_LOW && !req.is_signed |=>
		rsp.product == $past(req.src_a[15:0]) * $past(req.src_b[15:0]);
	endproperty
	a_low_u: assert property (p_low_u) else $error("low unsigned");

	// A result follows every request
	property p_valid;
		@(posedge mclk) disable iff (!rst_n)
		req.valid |=> rsp.valid;
	endproperty
	a_valid: assert property (p_valid) else $error("no result");

	// No result without a request
	property p_idle;
		@(posedge mclk) disable iff (!rst_n)
		!req.valid |=> !rsp.valid;
	endproperty
	a_idle: assert property (p_idle) else $error("stray result");

	// Product holds between requests
	property p_hold;
		@(posedge mclk) disable iff (!rst_n)
		!req.valid |=> $stable(rsp.product);
	endproperty
	a_hold: assert property (p_hold) else $error("product moved");

	// Field write only rides on a result
	property p_we;
		@(posedge mclk) disable iff (!rst_n)
		rsp.cr_we |-> rsp.valid;
	endproperty
	a_we: assert property (p_we) else $error("cr write alone");

	// Exactly one of lt, gt, eq on a recorded result
	property p_onehot;
		@(posedge mclk) disable iff (!rst_n)
		rsp.cr_we |-> $onehot(rsp.cr_field[3:1]);
	endproperty
	a_onehot: assert property (p_onehot) else $error("cr not one hot");

	// Zero product sets eq only
	property p_zero;
		@(posedge mclk) disable iff (!rst_n)
		rsp.cr_we && rsp.product == 32'h0000_0000 |->
		rsp.cr_field[3:1] == 3'h1;
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag");

endmodule : hwm_unit

/* pkg/hwm_regs.svh */
/*
 Constants for the halfword multiply unit: operand bit positions,
 condition field layout and reset values.
 Assumes big-endian bit numbering: architectural bit 0 is data bit 31.
*/
`ifndef HWM_REGS_SVH
`define HWM_REGS_SVH

`define HWM_HI_MSB    31
`define HWM_HI_LSB    16
`define HWM_LO_MSB    15
`define HWM_LO_LSB    0
`define HWM_CR_LT     3
`define HWM_CR_GT     2
`define HWM_CR_EQ     1
`define HWM_CR_SO     0
`define HWM_SO_BIT    31
`define HWM_RST_WORD  32'h0000_0000
`define HWM_RST_CR    4'h0

`endif

/* pkg/hwm_pkg.sv */
/*
 Types shared by the halfword multiply unit.
 Assumes nothing of its surroundings.
*/
package hwm_pkg;
	typedef enum logic [1:0] {
		HWM_SEL_CROSS,
		HWM_SEL_HIGH,
		HWM_SEL_LOW
	} hwm_sel_t;

	typedef struct packed {
		logic     valid;
		hwm_sel_t sel;
		logic     is_signed;
		logic     record;
		logic [31:0] src_a;
		logic [31:0] src_b;
		logic [31:0] fixed_point_exception_reg;
	} hwm_req_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] product;
		logic        cr_we;
		logic [3:0]  cr_field;
	} hwm_rsp_t;
endpackage : hwm_pkg

/* tb/hwm_wb_model.sv */
/*
 Writeback partner: destination register and result condition field.
 Assumes the unit's response struct, one clock, async low reset.
*/
module hwm_wb_model
	import hwm_pkg::*;
(
	// Clock and reset
	input  wire logic     mclk,
	input  wire logic     rst_n,
	// Result from the unit
	input  wire hwm_rsp_t rsp,
	// Architectural state
	output logic [31:0]   dst_ff,
	output logic [3:0]    cr_ff
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dst_ff <= 32'h0;
			cr_ff  <= 4'h0;
		end else begin
			if (rsp.valid) dst_ff <= rsp.product;
			// Field only written on request, so plain forms keep it
			if (rsp.cr_we) cr_ff <= rsp.cr_field;
		end
	end
endmodule : hwm_wb_model

/* tb/halfword_multiply_unit_tb.sv */
/*
 Self-checking bench for the halfword multiply unit.
 Assumes one-cycle latency and the {lt,gt,eq,so} field order.
*/
module halfword_multiply_unit_tb
	import hwm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, rst_n;
	hwm_req_t    req;
	hwm_rsp_t    rsp;
	logic [31:0] dst;
	logic [3:0]  cr;
	int          error_cnt, checked;
	hwm_unit dut (.mclk(mclk), .rst_n(rst_n), .req(req), .rsp(rsp));
	hwm_wb_model wb (.mclk(mclk), .rst_n(rst_n), .rsp(rsp), .dst_ff(dst),
		.cr_ff(cr));
	////////////////////////////////////////////////////////////////////
	task chk(string n, logic [31:0] s, logic [31:0] e);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s exp %h saw %h", n, e, s);
		end
	endtask : chk
	task conclude;
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude
	task op(hwm_sel_t s, logic sg, logic rc, logic [31:0] a,
		logic [31:0] b, logic so = 1'b1);
		logic [15:0]        x, y;
		logic signed [31:0] e;
		logic [3:0]         c0, f;
		x = (s == HWM_SEL_HIGH) ? a[31:16] : a[15:0];
		y = (s == HWM_SEL_LOW) ? b[15:0] : b[31:16];
		if (sg) e = $signed(x) * $signed(y);
		else e = x * y;
		f = {e < 0, e > 0, e == 0, so};
		c0 = cr;
		@(posedge mclk);
		req <= '{1'b1, s, sg, rc, a, b, {so, 31'h0}};
		@(posedge mclk);
		req.valid <= 1'b0;
		#1;
		chk("valid", rsp.valid, 1);
		chk("product", rsp.product, e);
		chk("cr_we", rsp.cr_we, rc);
		if (rc) chk("cr_field", rsp.cr_field, f);
		@(posedge mclk);
		#1;
		chk("pulse", rsp.valid, 0);
		chk("dst", dst, e);
		chk("cr", cr, rc ? f : c0);
	endtask : op
	task t_forms;
		for (int s = 0; s < 3; s++)
			for (int g = 0; g < 2; g++)
				op(hwm_sel_t'(s), g[0], 1'b0, 32'hfffe_0003, 32'h8000_fff9);
	endtask : t_forms
	task t_record;
		op(HWM_SEL_LOW, 1'b1, 1'b1, 32'h1234_0000, 32'h0000_0005);
		op(HWM_SEL_CROSS, 1'b1, 1'b1, 32'h0000_ffff, 32'h0002_0000);
		op(HWM_SEL_HIGH, 1'b0, 1'b0, 32'h7fff_0000, 32'h0003_0000);
		op(HWM_SEL_HIGH, 1'b0, 1'b1, 32'hffff_0000, 32'hffff_0000);
		op(HWM_SEL_LOW, 1'b0, 1'b1, 32'h0000_0003, 32'h0000_0004, 1'b0);
		op(HWM_SEL_CROSS, 1'b0, 1'b0, 32'h0000_0002, 32'h0005_0000);
	endtask : t_record
	task t_reset;
		@(posedge mclk);
		rst_n <= 1'b0;
		@(posedge mclk);
		#1;
		chk("mid reset product", rsp.product, 32'h0);
		chk("mid reset cr", cr, 4'h0);
		@(posedge mclk);
		rst_n <= 1'b1;
	endtask : t_reset
	////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		req = '0;
		rst_n = 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		#1;
		chk("reset rsp", rsp.product, 32'h0);
		t_forms();
		t_reset();
		t_record();
		conclude();
	end
endmodule : halfword_multiply_unit_tb
